// ---- psc_host_model.sv ----
// Serial bus host model that reaches the block's registers.
`timescale 1ns/1ns
`default_nettype none
module psc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h32 // Device bus address.
) (
  input wire logic clk,     // Bench clock.
  input wire logic sdaLine, // Resolved data wire.
  output logic scl,         // Serial clock.
  output logic sdaLow,      // High pulls the data wire low.
  output logic ackMiss      // Set when a byte went unacknowledged.
);
  logic [7:0] rdBuf [2]; // Bytes of the latest read.
  // --------
  // Bus primitives
  // --------
  // Idle bus: clock high, data released to its pull-up.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    ackMiss = 1'b0;
  end
  // Changes land just after an edge; a bit holds the clock low 7 clocks and high 5.
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic got);
    pause(2);
    sdaLow = !b;
    pause(5);
    scl = 1'b1;
    pause(5);
    got = sdaLine;
    scl = 1'b0;
  endtask
  // Start or stop: data moves while the clock is high.
  task automatic edge_cond(input logic isStart);
    pause(2);
    sdaLow = !isStart;
    pause(5);
    scl = 1'b1;
    pause(5);
    sdaLow = isStart;
    pause(5);
    scl = !isStart;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ackBit,
                         input logic chk, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ackBit, a);
    if (chk && a) ackMiss = 1'b1;
  endtask
  // single register write: device address, register pointer, one data byte
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] x;
    edge_cond(1'b1);
    byte_io({DEV_ADDR, 1'b0}, 1'b1, 1'b1, x);
    byte_io(addr, 1'b1, 1'b1, x);
    byte_io(data, 1'b1, 1'b1, x);
    edge_cond(1'b0);
  endtask
  task automatic read_regs(input logic [7:0] addr, input int n);
    logic [7:0] x;
    edge_cond(1'b1);
    byte_io({DEV_ADDR, 1'b0}, 1'b1, 1'b1, x);
    byte_io(addr, 1'b1, 1'b1, x);
    edge_cond(1'b1);
    byte_io({DEV_ADDR, 1'b1}, 1'b1, 1'b1, x);
    for (int k = 0; k < n; k++) byte_io(8'hFF, k == n - 1, 1'b0, rdBuf[k]);
    edge_cond(1'b0);
  endtask
  task automatic read_stable(input logic [7:0] addr, input int n);
    logic [7:0] prev [2];
    for (int t = 0; t < 4; t++) begin
      prev = rdBuf;
      read_regs(addr, n);
      if (t > 0 && prev == rdBuf) break;
    end
  endtask
endmodule
`default_nettype wire

// ---- psc_map.svh ----
// Register map, field positions, reset values and timing figures.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_A_CHIPVER 8'h00
`define PSC_A_OTP_VERSION 8'h01
`define PSC_A_IOTHR 8'h02
`define PSC_A_INTHR 8'h03
`define PSC_A_CLKOUT 8'h05
`define PSC_A_HOSTIF 8'h06
`define PSC_A_SWATCH 8'h07
`define PSC_A_ONHIS 8'h09
`define PSC_A_OFFHIS 8'h0A
`define PSC_A_WDSET 8'h0B
`define PSC_A_WDCNT 8'h0C
`define PSC_A_PFUNC 8'h0D
`define PSC_A_SLPCMD 8'h0E
`define PSC_A_REPCTL 8'h0F
`define PSC_A_BTNSET 8'h10
`define PSC_A_PREIN 8'hB0
`define PSC_A_OVERTEMP_THRESHOLD 8'hBC
`define PSC_M_IOTHR 8'h3F
`define PSC_M_INTHR 8'h97
`define PSC_M_CLKOUT 8'h1E
`define PSC_M_HOSTIF 8'h03
`define PSC_M_WDSET 8'h0F
`define PSC_M_PFUNC 8'h22
`define PSC_M_REPCTL 8'h37
`define PSC_M_BTNSET 8'hFF
`define PSC_M_PREIN 8'h07
`define PSC_M_OVERTEMP_THRESHOLD 8'h03
`define PSC_R_ZERO 8'h00
`define PSC_R_WDSET 8'h03
`define PSC_R_BTNSET 8'h38
`define PSC_B_INCDIS 1
`define PSC_B_RETAIN 7
`define PSC_B_INKEEP 7
`define PSC_B_WDRUN 3
`define PSC_B_WDOFF 2
`define PSC_B_SLPOFF 5
`define PSC_B_OFFSEL 1
`define PSC_B_EXIT 5
`define PSC_B_ENTRY 4
`define PSC_B_SWOFF 0
`define PSC_B_REPWR 0
`define PSC_B_BTNCLR 7
`define PSC_B_JUDGE 3
`define PSC_LAST_SLOT 4'hF
`define PSC_WD_UNITS_SHORT 8'h28
`define PSC_WD_UNITS_LONG 8'hA0
`define PSC_MS_PER_S 14'h03E8
`endif

// ---- psc_pkg.sv ----
// Types shared by the power-state control block.
package psc_pkg;
  typedef enum logic [3:0] {
    PS_OFF, PS_ON_SEQ, PS_HOLD, PS_ON, PS_SLP_ENT, PS_SLEEP,
    PS_SLP_EXIT, PS_OFF_SEQ, PS_REPWR
  } psc_state_e;
  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_REG_ACK,
    BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK
  } psc_bus_e;
  typedef logic [13:0] psc_ms_t;
endpackage

// ---- psc_power_control.sv ----
// Power-state sequencer with watchdog, button timers and serial registers.
`timescale 1ns/1ns
`default_nettype none
`include "psc_map.svh"
module psc_power_control import psc_pkg::*; #(
  parameter int TICK_CYCLES = 50000,          // Clock cycles per 1 ms.
  parameter logic [6:0] DEV_ADDR = 7'h32,     // Bus address.
  parameter logic [7:0] CHIP_VERSION = 8'h5A, // Arbitrary value.
  parameter logic [7:0] OTP_VERSION = 8'hC3   // Arbitrary value.
) (
  input wire logic clk,           // 50 MHz clock.
  input wire logic rst_n,         // Synchronous reset, active low.
  input wire logic uvLockout,     // Undervoltage lockout, high active.
  input wire logic scl,           // Serial clock.
  input wire logic sdaIn,         // Serial data level.
  output logic sdaOut,            // Serial data driven value.
  output logic sdaDriveN,         // Low while driving serial data.
  input wire logic buttonIn,      // Power button held, high.
  input wire logic extOnIn,       // External power-on input.
  input wire logic powerHoldIn,   // Power hold from host, high.
  input wire logic holdTimeout,   // Power hold timeout event.
  input wire logic hardResetIn,   // Hard reset request.
  input wire logic outEnableN,    // Output enable, low drops power.
  input wire logic overCurrent,   // Converter overcurrent.
  input wire logic ioDetect,      // I/O supply detector.
  input wire logic inDetect,      // Input supply detector.
  input wire logic thermalTrip,   // Thermal shutdown.
  input wire logic wdEnLock,      // Locks watchdog off-enable writes.
  output logic resetOutN,         // Reset output to host, low.
  output logic railsOn,           // Rails requested on.
  output logic [3:0] seqSlot,     // Current sequence slot.
  output logic offAllAtLast,      // Off sequence ends all at slot 15.
  output logic sleepActive,       // In sleep state.
  output logic wdExpired          // One-cycle watchdog expiry pulse.
);
  // ----------------------------------------------------------------
  // Millisecond divider and sampled pins
  // ----------------------------------------------------------------
  logic [15:0] divCnt;
  logic msTick;
  logic sclQ, sdaQ, sclP, sdaP, extP, btnQ;
  wire divWrap = (divCnt == 16'(TICK_CYCLES - 1));
  // Divider makes one tick per millisecond.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt <= '0;
      msTick <= 1'b0;
    end else begin
      divCnt <= divWrap ? '0 : divCnt + 16'h0001;
      msTick <= divWrap;
    end
  end
  // Serial pins pass two registers and the external-on and button pins one, for edge detection.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      sclP <= 1'b1;
      sdaP <= 1'b1;
      extP <= 1'b0;
      btnQ <= 1'b0;
    end else begin
      sclQ <= scl;
      sdaQ <= sdaIn;
      sclP <= sclQ;
      sdaP <= sdaQ;
      extP <= extOnIn;
      btnQ <= buttonIn;
    end
  end
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] ioThr, inThr, clkOut, hostIf, sWatch, onHis, offHis;
  logic [7:0] wdSet, pFunc, repCtl, btnSet, preIn, overtemp_threshold, ptr;
  logic [7:0] wdUnits;
  logic wrStb, rdStb;
  logic [7:0] wrData;
  psc_state_e state, next_state;
  // Read selection over the mapped offsets; unmapped reads give zero.
  wire [7:0] rdMux =
    (ptr == `PSC_A_CHIPVER) ? CHIP_VERSION :
    (ptr == `PSC_A_OTP_VERSION) ? OTP_VERSION :
    (ptr == `PSC_A_IOTHR) ? ioThr :
    (ptr == `PSC_A_INTHR) ? inThr :
    (ptr == `PSC_A_CLKOUT) ? clkOut :
    (ptr == `PSC_A_HOSTIF) ? hostIf :
    (ptr == `PSC_A_SWATCH) ? sWatch :
    (ptr == `PSC_A_ONHIS) ? onHis :
    (ptr == `PSC_A_OFFHIS) ? offHis :
    (ptr == `PSC_A_WDSET) ? wdSet :
    (ptr == `PSC_A_WDCNT) ? wdUnits :
    (ptr == `PSC_A_PFUNC) ? pFunc :
    (ptr == `PSC_A_REPCTL) ? repCtl :
    (ptr == `PSC_A_BTNSET) ? btnSet :
    (ptr == `PSC_A_PREIN) ? preIn :
    (ptr == `PSC_A_OVERTEMP_THRESHOLD) ? overtemp_threshold : `PSC_R_ZERO;
  wire wrHit = wrStb;
  wire wIo = wrHit && ptr == `PSC_A_IOTHR;
  wire wIn = wrHit && ptr == `PSC_A_INTHR;
  wire wClk = wrHit && ptr == `PSC_A_CLKOUT;
  wire wHost = wrHit && ptr == `PSC_A_HOSTIF;
  wire wWatch = wrHit && ptr == `PSC_A_SWATCH;
  wire wWd = wrHit && ptr == `PSC_A_WDSET;
  wire wFunc = wrHit && ptr == `PSC_A_PFUNC;
  wire wSlp = wrHit && ptr == `PSC_A_SLPCMD;
  wire wRep = wrHit && ptr == `PSC_A_REPCTL;
  wire wBtn = wrHit && ptr == `PSC_A_BTNSET;
  wire wPre = wrHit && ptr == `PSC_A_PREIN;
  wire wOvt = wrHit && ptr == `PSC_A_OVERTEMP_THRESHOLD;
  wire wdAccess = (wrHit || rdStb) && ptr == `PSC_A_WDSET;
  wire cmdExit = wSlp && wrData[`PSC_B_EXIT];
  wire cmdEntry = wSlp && wrData[`PSC_B_ENTRY];
  wire cmdOff = wSlp && wrData[`PSC_B_SWOFF];
  // retain bit masks the off-state reset.
  wire offRst = next_state == PS_OFF && state != PS_OFF &&
    !sWatch[`PSC_B_RETAIN];
  wire lockRst = !rst_n || uvLockout;
  wire anyRst = lockRst || offRst;
  wire inRst = anyRst && !(offRst && inThr[`PSC_B_INKEEP] && !lockRst);
  wire [7:0] wdMask = wdEnLock ?
    (`PSC_M_WDSET & ~(8'h01 << `PSC_B_WDOFF)) : `PSC_M_WDSET;
  // Registers cleared on entering off unless the retain bit is set, or at reset; button setting loads 8'h38.
  always_ff @(posedge clk) begin
    if (anyRst) begin
      ioThr <= `PSC_R_ZERO;
      clkOut <= `PSC_R_ZERO;
      hostIf <= `PSC_R_ZERO;
      pFunc <= `PSC_R_ZERO;
      repCtl <= `PSC_R_ZERO;
      btnSet <= `PSC_R_BTNSET;
    end else begin
      if (wIo) ioThr <= wrData & `PSC_M_IOTHR;
      if (wClk) clkOut <= wrData & `PSC_M_CLKOUT;
      if (wHost) hostIf <= wrData & `PSC_M_HOSTIF;
      if (wFunc) pFunc <= wrData & `PSC_M_PFUNC;
      if (wRep) repCtl <= wrData & `PSC_M_REPCTL;
      if (wBtn) btnSet <= wrData & `PSC_M_BTNSET;
    end
  end
  // Watchdog setting keeps its own default.
  always_ff @(posedge clk) begin
    if (anyRst) begin
      wdSet <= `PSC_R_WDSET;
    end else if (wWd) begin
      wdSet <= (wrData & wdMask) | (wdSet & ~wdMask);
    end
  end
  // Input threshold keep bit survives off-state reset.
  always_ff @(posedge clk) begin
    if (lockRst) begin
      inThr <= `PSC_R_ZERO;
    end else if (inRst) begin
      inThr <= inThr & (8'h01 << `PSC_B_INKEEP);
    end else if (wIn) begin
      inThr <= wrData & `PSC_M_INTHR;
    end
  end
  always_ff @(posedge clk) begin
    if (lockRst) begin
      sWatch <= `PSC_R_ZERO;
      preIn <= `PSC_R_ZERO;
      overtemp_threshold <= `PSC_R_ZERO;
    end else begin
      if (wWatch) sWatch <= wrData;
      if (wPre) preIn <= wrData & `PSC_M_PREIN;
      if (wOvt) overtemp_threshold <= wrData & `PSC_M_OVERTEMP_THRESHOLD;
    end
  end
  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  psc_bus_e bus;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic rdMode, ackOk;
  wire sclRise = sclQ && !sclP;
  wire sclFall = !sclQ && sclP;
  wire startCond = sclQ && sclP && sdaP && !sdaQ;
  wire stopCond = sclQ && sclP && !sdaP && sdaQ;
  wire byteDone = bitCnt == 4'h8;
  wire incDis = hostIf[`PSC_B_INCDIS];
  wire [7:0] ptrNext = incDis ? ptr : ptr + 8'h01;
  // Byte-level slave: address, register pointer, then data.
  always_ff @(posedge clk) begin
    if (!rst_n || startCond || stopCond) begin
      bus <= (rst_n && startCond) ? BUS_ADDR : BUS_IDLE;
      bitCnt <= '0;
      sdaDriveN <= 1'b1;
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      if (!rst_n) begin
        shift <= '0;
        rdMode <= 1'b0;
        ptr <= '0;
        wrData <= '0;
        ackOk <= 1'b0;
      end
    end else begin
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      if (sclRise && bus inside {BUS_ADDR, BUS_REG, BUS_WR}) begin
        shift <= {shift[6:0], sdaQ};
        bitCnt <= bitCnt + 4'h1;
      end
      if (sclRise && bus == BUS_RD_ACK) ackOk <= !sdaQ;
      if (sclFall) begin
        unique case (bus)
          BUS_IDLE: bus <= BUS_IDLE;
          BUS_ADDR: if (byteDone) begin
            bitCnt <= '0;
            rdMode <= shift[0];
            bus <= (shift[7:1] == DEV_ADDR) ? BUS_ADDR_ACK : BUS_IDLE;
            sdaDriveN <= shift[7:1] != DEV_ADDR;
          end
          BUS_ADDR_ACK: begin
            bus <= rdMode ? BUS_RD : BUS_REG;
            shift <= rdMux;
            rdStb <= rdMode;
            sdaDriveN <= rdMode ? rdMux[7] : 1'b1;
          end
          BUS_REG: if (byteDone) begin
            bitCnt <= '0;
            bus <= BUS_REG_ACK;
            ptr <= shift;
            sdaDriveN <= 1'b0;
          end
          BUS_REG_ACK, BUS_WR_ACK: begin
            bus <= BUS_WR;
            sdaDriveN <= 1'b1;
          end
          BUS_WR: if (byteDone) begin
            bitCnt <= '0;
            bus <= BUS_WR_ACK;
            wrData <= shift;
            wrStb <= 1'b1;
            sdaDriveN <= 1'b0;
          end
          BUS_RD: begin
            bitCnt <= bitCnt + 4'h1;
            shift <= {shift[6:0], 1'b0};
            sdaDriveN <= (bitCnt == 4'h7) ? 1'b1 : shift[6];
            if (bitCnt == 4'h7) bus <= BUS_RD_ACK;
          end
          BUS_RD_ACK: begin
            bitCnt <= '0;
            bus <= ackOk ? BUS_RD : BUS_IDLE;
            sdaDriveN <= ackOk ? rdMux[7] : 1'b1;
            shift <= rdMux;
            rdStb <= ackOk;
          end
        endcase
      end
      // Pointer moves after each data byte is taken or loaded, unless the hostIf increment-disable bit holds it.
      if (wrStb || rdStb) ptr <= ptrNext;
    end
  end
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [9:0] wdSub;
  wire [1:0] wdCode = wdSet[1:0];
  wire [9:0] wdLsb = (wdCode == 2'b00) ? 10'd25 : (wdCode == 2'b01) ?
    10'd50 : (wdCode == 2'b10) ? 10'd200 : 10'd800;
  wire [7:0] wdLoad = (wdCode == 2'b00) ? `PSC_WD_UNITS_SHORT :
    `PSC_WD_UNITS_LONG;
  wire wdRun = state == PS_ON ||
    (state == PS_SLEEP && wdSet[`PSC_B_WDRUN]);
  wire wdStep = wdRun && msTick && (wdSub == wdLsb - 10'd1);
  wire wdFire = wdStep && wdUnits == 8'h00;
  // Count down remaining units; reload on access or when idle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdUnits <= `PSC_WD_UNITS_LONG;
      wdSub <= '0;
      wdExpired <= 1'b0;
    end else begin
      wdExpired <= wdFire;
      if (wdAccess || wdFire ||
          !(state == PS_ON || state == PS_SLEEP)) begin
        wdUnits <= wdLoad;
        wdSub <= '0;
      end else if (wdRun && msTick) begin
        wdSub <= wdStep ? '0 : wdSub + 10'd1;
        if (wdStep) wdUnits <= wdUnits - 8'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Power button timers
  // ----------------------------------------------------------------
  psc_ms_t btnCnt, btnLim;
  logic btnOvf;
  wire psc_ms_t onLim = (btnSet[2:0] == 3'd1) ? 14'd20 :
    (btnSet[2:0] == 3'd2) ? 14'd128 : (btnSet[2:0] == 3'd3) ? 14'd1000 :
    (btnSet[2:0] == 3'd4) ? 14'd2000 : (btnSet[2:0] == 3'd5) ? 14'd3000 :
    14'd0;
  wire psc_ms_t judge = btnSet[`PSC_B_JUDGE] ? `PSC_MS_PER_S : 14'd0;
  wire [3:0] offSec = (btnSet[6:4] < 3'd3) ? {1'b0, btnSet[6:4]} :
    {btnSet[6:4] - 3'd1, 1'b0};
  wire psc_ms_t offLim = psc_ms_t'(offSec * `PSC_MS_PER_S) + judge;
  wire btnClr = btnSet[`PSC_B_BTNCLR];
  wire btnHit = btnQ && !btnOvf && btnCnt >= btnLim && !btnClr;
  // Press timer; clear bit holds timer and overflow at zero.
  always_ff @(posedge clk) begin
    if (!rst_n || btnClr || !btnQ) begin
      btnCnt <= '0;
      btnOvf <= 1'b0;
    end else begin
      if (msTick && btnCnt != '1) btnCnt <= btnCnt + 14'd1;
      if (btnHit) btnOvf <= 1'b1;
    end
  end
  assign btnLim = (state == PS_OFF) ? onLim : offLim;
  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  psc_ms_t tmr;
  logic hardLatch;
  wire seqState = state inside {PS_ON_SEQ, PS_SLP_ENT, PS_SLP_EXIT,
    PS_OFF_SEQ};
  wire seqDone = msTick && seqSlot == `PSC_LAST_SLOT;
  wire hostOff = !powerHoldIn || holdTimeout;
  wire [7:0] offCause = {!outEnableN || hardResetIn, overCurrent,
    wdFire && wdSet[`PSC_B_WDOFF], hostOff, ioDetect, inDetect,
    thermalTrip, btnHit};
  wire [7:0] onCause = offCause | {3'b000, cmdOff, 4'h0};
  wire [7:0] slpCause = {offCause[7:1],
    btnHit && pFunc[`PSC_B_SLPOFF]};
  wire psc_ms_t holdMs = (repCtl[5:4] == 2'b01) ? 14'd2 :
    (repCtl[5:4] == 2'b10) ? 14'd8 : (repCtl[5:4] == 2'b11) ? 14'd16 :
    14'd0;
  wire psc_ms_t repMs = (repCtl[2:1] == 2'b01) ? 14'd100 :
    (repCtl[2:1] == 2'b10) ? 14'd500 : (repCtl[2:1] == 2'b11) ?
    14'd1000 : 14'd10;
  wire extRise = extOnIn && !extP;
  // commands count only in their own state.
  always_comb begin
    next_state = state;
    unique case (state)
      PS_OFF: if (extRise || btnHit) next_state = PS_ON_SEQ;
      PS_ON_SEQ: if (seqDone) next_state = PS_HOLD;
      PS_HOLD: if (tmr >= holdMs) next_state = PS_ON;
      PS_ON: begin
        if (onCause != 8'h00) next_state = PS_OFF_SEQ;
        else if (cmdEntry) next_state = PS_SLP_ENT;
      end
      PS_SLP_ENT: if (seqDone) next_state = PS_SLEEP;
      PS_SLEEP: begin
        if (slpCause != 8'h00) next_state = PS_OFF_SEQ;
        else if (cmdExit) next_state = PS_SLP_EXIT;
      end
      PS_SLP_EXIT: if (seqDone) next_state = PS_ON;
      PS_OFF_SEQ: if (seqDone) next_state =
        (repCtl[`PSC_B_REPWR] || hardLatch) ? PS_REPWR : PS_OFF;
      PS_REPWR: if (msTick && tmr >= repMs - 14'd1) next_state = PS_ON_SEQ;
    endcase
  end
  // State, slot stepping and wait timer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PS_OFF;
      seqSlot <= '0;
      tmr <= '0;
      hardLatch <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        seqSlot <= '0;
        tmr <= '0;
      end else begin
        if (seqState && msTick) seqSlot <= seqSlot + 4'h1;
        if (msTick) tmr <= tmr + 14'd1;
      end
      if (state == PS_ON && onCause[7] && hardResetIn) hardLatch <= 1'b1;
      else if (state == PS_ON_SEQ) hardLatch <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (lockRst) begin
      onHis <= `PSC_R_ZERO;
    end else if (next_state == PS_ON_SEQ && state != PS_ON_SEQ) begin
      onHis <= {4'h0, state == PS_OFF && extRise, 1'b0,
        state == PS_REPWR, state == PS_OFF && btnHit && !extRise};
    end
  end
  always_ff @(posedge clk) begin
    if (lockRst) begin
      offHis <= `PSC_R_ZERO;
    end else if (next_state == PS_OFF_SEQ && state != PS_OFF_SEQ) begin
      offHis <= (state == PS_ON) ? onCause : slpCause;
    end
  end
  // off timing and rail request outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetOutN <= 1'b0;
      railsOn <= 1'b0;
      offAllAtLast <= 1'b0;
      sleepActive <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      resetOutN <= next_state inside {PS_ON, PS_SLP_ENT, PS_SLEEP,
        PS_SLP_EXIT};
      railsOn <= !(next_state inside {PS_OFF, PS_REPWR});
      offAllAtLast <= pFunc[`PSC_B_OFFSEL];
      sleepActive <= next_state == PS_SLEEP;
      sdaOut <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- psc_power_control_chk.sv ----
// Port-level assertions for the power-state control block.
`timescale 1ns/1ns
`default_nettype none
module psc_power_control_chk (
  input wire logic clk,           // Clock.
  input wire logic rst_n,         // Reset, active low.
  input wire logic thermalTrip,   // Thermal shutdown.
  input wire logic sdaOut,        // Serial data value.
  input wire logic sdaDriveN,     // Serial data drive, low.
  input wire logic resetOutN,     // Host reset, low.
  input wire logic railsOn,       // Rails requested.
  input wire logic [3:0] seqSlot, // Sequence slot.
  input wire logic sleepActive,   // Sleep state.
  input wire logic wdExpired      // Watchdog pulse.
);
  // --------
  // Assertions
  // --------
  // All checks share one clock and are idle during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("serial data driven high");
  reset_idle_a: assert property ($rose(rst_n) |-> !railsOn && sdaDriveN)
    else $error("outputs not idle after reset");
  off_reset_low_a: assert property (!railsOn |-> !resetOutN)
    else $error("host reset released with rails off");
  power_up_hold_a: assert property ($rose(railsOn) |-> !resetOutN [*8])
    else $error("host reset released during power-up");
  sleep_power_a: assert property (sleepActive |-> railsOn && resetOutN)
    else $error("sleep without rails or with reset");
  wd_pulse_a: assert property (wdExpired |=> !wdExpired)
    else $error("watchdog pulse longer than one cycle");
  slot_step_a: assert property ($changed(seqSlot) |->
    seqSlot == 4'h0 || seqSlot == $past(seqSlot) + 4'h1)
    else $error("sequence slot skipped");
  thermal_off_a: assert property ($rose(thermalTrip) && railsOn |->
    ##[1:1000] !railsOn)
    else $error("thermal trip did not drop rails");
endmodule
bind psc_power_control psc_power_control_chk psc_power_control_chk_i (
  .clk(clk), .rst_n(rst_n), .thermalTrip(thermalTrip), .sdaOut(sdaOut),
  .sdaDriveN(sdaDriveN), .resetOutN(resetOutN), .railsOn(railsOn),
  .seqSlot(seqSlot), .sleepActive(sleepActive), .wdExpired(wdExpired));
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the power-state control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [7:0] CHIP_V = 8'h3C; // Arbitrary version value.
  logic clk, rst_n, uv, btn, extOn, hold, oeN, thr, lock, scl, sdaLow;
  logic ackMiss, sdaOut, sdaDriveN, resetOutN, railsOn, offAllAtLast;
  logic sleepActive, wdExpired;
  logic hto, hrst, oc, ioD, inD;
  logic [3:0] seqSlot;
  logic [7:0] adr [6];
  logic [7:0] exv [6];
  logic [7:0] cause [9];
  wire logic sdaLine;
  int bad_count, checks, n;
  // Open-drain data wire with pull-up.
  assign sdaLine = !(sdaLow || !sdaDriveN);
  psc_power_control #(.TICK_CYCLES(10), .CHIP_VERSION(CHIP_V))
    psc_power_control_i (.clk(clk), .rst_n(rst_n), .uvLockout(uv),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
    .buttonIn(btn), .extOnIn(extOn), .powerHoldIn(hold),
    .holdTimeout(hto), .hardResetIn(hrst), .outEnableN(oeN),
    .overCurrent(oc), .ioDetect(ioD), .inDetect(inD),
    .thermalTrip(thr), .wdEnLock(lock), .resetOutN(resetOutN),
    .railsOn(railsOn), .seqSlot(seqSlot), .offAllAtLast(offAllAtLast),
    .sleepActive(sleepActive), .wdExpired(wdExpired));
  psc_host_model #(.DEV_ADDR(7'h32)) psc_host_model_i (.clk(clk),
    .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow), .ackMiss(ackMiss));
  // --------
  // Checking tasks
  // --------
  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic in_range(input string what, input int lo, input int hi,
                          input int s);
    checks++;
    if (s < lo || s > hi) begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    psc_host_model_i.read_regs(a, 1);
    cmp($sformatf("register %h", a), e, psc_host_model_i.rdBuf[0]);
  endtask
  // Waits a bounded number of cycles for a level, counting them.
  task automatic wait_sig(ref logic s, input logic v, input int lim,
                          output int c);
    for (c = 0; c < lim && s !== v; c++) begin
      @(posedge clk);
      #1;
    end
    cmp("wait", {7'h00, v}, {7'h00, s});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------
  // Clock, watchdog and tests
  // --------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  initial begin
    {rst_n, uv, btn, extOn, hold, oeN, thr, lock} = 8'h0C;
    {hto, hrst, oc, ioD, inD} = 5'h00;
    adr = '{8'h00, 8'h04, 8'h07, 8'h0B, 8'h0E, 8'h10};
    exv = '{CHIP_V, 8'h00, 8'h00, 8'h03, 8'h00, 8'h38};
    cause = '{8'h02, 8'h10, 8'h80, 8'h10, 8'h10, 8'h40, 8'h80, 8'h08,
      8'h04};
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    psc_host_model_i.pause(2);
    foreach (adr[i]) rd(adr[i], exv[i]);
    extOn = 1'b1;
    wait_sig(resetOutN, 1'b1, 1000, n);
    extOn = 1'b0;
    rd(8'h09, 8'h08);
    psc_host_model_i.write_reg(8'h07, 8'hAA);
    rd(8'h07, 8'hAA);
    for (int c = 0; c < 4; c++) begin
      psc_host_model_i.write_reg(8'h0B, 8'(c));
      psc_host_model_i.read_stable(8'h0B, 2);
      cmp("count", (c == 0) ? 8'h28 : 8'hA0, psc_host_model_i.rdBuf[1]);
    end
    psc_host_model_i.write_reg(8'h06, 8'h02);
    psc_host_model_i.read_regs(8'h0B, 2);
    cmp("fixed pointer", 8'h03, psc_host_model_i.rdBuf[1]);
    psc_host_model_i.write_reg(8'h06, 8'h00);
    psc_host_model_i.write_reg(8'h0D, 8'h02);
    cmp("all at last", 8'h01, {7'h00, offAllAtLast});
    psc_host_model_i.write_reg(8'h0E, 8'h20);
    cmp("sleep", 8'h00, {7'h00, sleepActive});
    psc_host_model_i.write_reg(8'h0E, 8'h10);
    wait_sig(sleepActive, 1'b1, 400, n);
    psc_host_model_i.write_reg(8'h0E, 8'h20);
    wait_sig(sleepActive, 1'b0, 400, n);
    lock = 1'b1;
    psc_host_model_i.write_reg(8'h0B, 8'h04);
    rd(8'h0B, 8'h00);
    lock = 1'b0;
    psc_host_model_i.write_reg(8'h0B, 8'h04);
    wait_sig(wdExpired, 1'b1, 12000, n);
    in_range("watchdog", 9900, 10400, n);
    wait_sig(railsOn, 1'b0, 400, n);
    rd(8'h0A, 8'h20);
    rd(8'h0B, 8'h04);
    btn = 1'b1;
    wait_sig(resetOutN, 1'b1, 1000, n);
    btn = 1'b0;
    rd(8'h09, 8'h01);
    psc_host_model_i.write_reg(8'h0B, 8'h07);
    psc_host_model_i.write_reg(8'h0F, 8'h21);
    for (int k = 0; k < 9; k++) begin
      case (k)
        0: thr = 1'b1;
        1: psc_host_model_i.write_reg(8'h0E, 8'h01);
        2: oeN = 1'b0;
        3: hold = 1'b0;
        4: hto = 1'b1;
        5: oc = 1'b1;
        6: hrst = 1'b1;
        7: ioD = 1'b1;
        default: inD = 1'b1;
      endcase
      wait_sig(railsOn, 1'b0, 400, n);
      {thr, oeN, hold, hto, hrst, oc, ioD, inD} = 8'h60;
      wait_sig(railsOn, 1'b1, 400, n);
      in_range("repower wait", 90, 120, n);
      wait_sig(resetOutN, 1'b1, 400, n);
      in_range("reset hold", 220, 260, n);
      rd(8'h0A, cause[k]);
      rd(8'h09, 8'h02);
    end
    uv = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    uv = 1'b0;
    rd(8'h07, 8'h00);
    cmp("ack", 8'h00, {7'h00, ackMiss});
    close_out();
  end
endmodule
`default_nettype wire
